// File: rtl/mtc_special_func.sv
`timescale 1ns/1ps
`include "mtc_defs.svh"
module mtc_special_func
    import mtc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire mtc_cond_t i_cond,
    input wire logic i_alt_clear_req,
    output logic [31:0] o_rdata,
    output logic o_wr_abort,
    output logic [31:0] o_abort_code,
    output logic o_clear_active,
    output logic o_prot_err,
    output logic o_irq
);

    localparam int MTC_RUN_MAX = `MTC_CLEAR_CYC;

    function automatic logic mtc_refuse(input mtc_cond_t c,
                                        input logic busy);
        mtc_refuse = c.servo_on | c.tool_clear_busy | c.incr_encoder
            | c.probe_active | (c.abs_mode == `MTC_ABS_SINGLE) | busy;
    endfunction : mtc_refuse

    function automatic logic mtc_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        mtc_hit = (a == off);
    endfunction : mtc_hit

    mtc_state_t state_q, state_d;
    logic [31:0] flags_q;
    logic [15:0] sel_q, sel_d;
    logic [`MTC_CNT_W-1:0] cnt_q, cnt_d;
    logic [`MTC_IRQ_W-1:0] sts_q, sts_d, msk_q, msk_d, sts_set;
    logic [31:0] code_q, code_d;
    logic [31:0] rdata_q, rd_val;
    logic abort_q, busy_q, prot_q, irq_q, refused_q, refused_d;

    // Decode
    wire wr_flags = i_wr && mtc_hit(i_addr, `MTC_OFF_FLAGS);
    wire wr_sel = i_wr && mtc_hit(i_addr, `MTC_OFF_SELECT);
    wire wr_sts = i_wr && mtc_hit(i_addr, `MTC_OFF_IRQ_STS);
    wire wr_msk = i_wr && mtc_hit(i_addr, `MTC_OFF_IRQ_MSK);
    wire in_fn = (state_q != MTC_IDLE);
    wire trig_rise = wr_flags && i_wdata[`MTC_TRIG_BIT]
        && !flags_q[`MTC_TRIG_BIT];
    wire is_clear = (sel_q == `MTC_SEL_CLEAR);
    wire refuse = mtc_refuse(i_cond, in_fn);
    wire go = trig_rise && is_clear && !refuse;
    wire reject = trig_rise && is_clear && refuse;
    wire run_end = (state_q == MTC_RUN) && (cnt_q == '0);

    // Sequencer; once running, a new start edge cannot restart or stop the clear and only raises an abort
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            MTC_IDLE: begin
                if (go) begin
                    state_d = MTC_RUN;
                    cnt_d = `MTC_CNT_W'(`MTC_CLEAR_CYC - 1);
                end
            end
            MTC_RUN: begin
                if (run_end) begin
                    state_d = MTC_DONE;
                end else begin
                    cnt_d = cnt_q - `MTC_CNT_W'(1);
                end
            end
            MTC_DONE: begin
                state_d = MTC_IDLE;
            end
            default: begin
                state_d = MTC_IDLE;
            end
        endcase
    end

    // Selection object: idle code after success, kept on abort
    assign sel_d = (state_q == MTC_DONE) ? `MTC_SEL_NONE
        : wr_sel ? i_wdata[15:0] : sel_q;
    assign code_d = reject ? `MTC_ABORT_BUSY
        : go ? `MTC_ABORT_NONE : code_q;
    assign refused_d = reject ? 1'b1 : go ? 1'b0 : refused_q;

    // Interrupt status, set wins over clear
    assign sts_set[`MTC_IRQ_DONE] = (state_q == MTC_DONE);
    assign sts_set[`MTC_IRQ_ABORT] = reject;
    genvar gi;
    generate
        for (gi = 0; gi < `MTC_IRQ_W; gi++) begin : g_sts
            assign sts_d[gi] = sts_set[gi]
                | (sts_q[gi] & ~(wr_sts & i_wdata[gi]));
        end
    endgenerate
    assign msk_d = wr_msk ? i_wdata[`MTC_IRQ_W-1:0] : msk_q;

    // Read mux
    assign rd_val = mtc_hit(i_addr, `MTC_OFF_FLAGS) ? flags_q
        : mtc_hit(i_addr, `MTC_OFF_SELECT) ? {16'h0000, sel_q}
        : mtc_hit(i_addr, `MTC_OFF_STATUS)
            ? {30'h00000000, refused_q, busy_q}
        : mtc_hit(i_addr, `MTC_OFF_ABORT) ? code_q
        : mtc_hit(i_addr, `MTC_OFF_IRQ_STS) ? {30'h00000000, sts_q}
        : mtc_hit(i_addr, `MTC_OFF_IRQ_MSK) ? {30'h00000000, msk_q}
        : 32'h00000000;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= MTC_IDLE;
            cnt_q <= '0;
            flags_q <= `MTC_FLAGS_RST;
            sel_q <= `MTC_SEL_NONE;
            code_q <= `MTC_ABORT_NONE;
            refused_q <= 1'b0;
            sts_q <= `MTC_IRQ_RST;
            msk_q <= `MTC_IRQ_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            flags_q <= wr_flags ? i_wdata : flags_q;
            sel_q <= sel_d;
            code_q <= code_d;
            refused_q <= refused_d;
            sts_q <= sts_d;
            msk_q <= msk_d;
        end
    end

    // Output flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 32'h00000000;
            abort_q <= 1'b0;
            busy_q <= 1'b0;
            prot_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= i_rd ? rd_val : 32'h00000000;
            abort_q <= reject;
            busy_q <= (state_d == MTC_RUN);
            prot_q <= i_alt_clear_req;
            irq_q <= |(sts_d & msk_d);
        end
    end

    assign o_rdata = rdata_q;
    assign o_wr_abort = abort_q;
    assign o_abort_code = code_q;
    assign o_clear_active = busy_q;
    assign o_prot_err = prot_q;
    assign o_irq = irq_q;

    a_idle_code_nop: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        trig_rise && (sel_q == `MTC_SEL_NONE) && !in_fn
        |=> !busy_q && !o_wr_abort)
        else $error("idle code started something");

    a_clear_starts: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        go |=> busy_q && !o_wr_abort)
        else $error("clear request did not start");

    a_sel_returns: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $fell(busy_q) |=> (sel_q == `MTC_SEL_NONE)
            && sts_q[`MTC_IRQ_DONE])
        else $error("selection not returned to idle");

    a_refuse_abort: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        reject |=> o_wr_abort && !$rose(busy_q))
        else $error("refused clear not aborted");

    a_abort_keeps: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        reject && !in_fn |=> (sel_q == `MTC_SEL_CLEAR)
            ##1 ((sel_q == `MTC_SEL_CLEAR) || $past(wr_sel)))
        else $error("abort changed selection");

    a_abort_code: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        trig_rise && is_clear && (i_cond.servo_on || busy_q)
        |=> o_wr_abort && (o_abort_code == `MTC_ABORT_BUSY))
        else $error("wrong abort code");

    a_cond_refuse: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        trig_rise && is_clear && (i_cond.probe_active
            || i_cond.incr_encoder
            || (i_cond.abs_mode == `MTC_ABS_SINGLE))
        |=> o_wr_abort && !$rose(busy_q))
        else $error("condition did not refuse clear");

    a_no_prot_err: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        go && !i_alt_clear_req |=> !o_prot_err)
        else $error("fieldbus clear raised protection error");

    a_edge_only: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        wr_flags && flags_q[`MTC_TRIG_BIT] |=> !$rose(busy_q))
        else $error("level started function");

    a_runs_through: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(busy_q) |-> busy_q [*8] ##[1:MTC_RUN_MAX] !busy_q)
        else $error("clear length wrong");

    // Checker: cycles spent in the current run
    logic [`MTC_CNT_W-1:0] chk_len_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            chk_len_q <= '0;
        end else begin
            chk_len_q <= busy_q ? chk_len_q + `MTC_CNT_W'(1) : '0;
        end
    end

    a_run_length: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $fell(busy_q) |-> (chk_len_q == `MTC_CNT_W'(MTC_RUN_MAX)))
        else $error("clear did not run its full length");

    a_run_bound: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        busy_q |-> (chk_len_q < `MTC_CNT_W'(MTC_RUN_MAX)))
        else $error("clear ran too long");

    a_drop_keeps_run: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        busy_q && wr_flags && !i_wdata[`MTC_TRIG_BIT]
        |=> busy_q || (state_q == MTC_DONE))
        else $error("dropping start bit stopped clear");

    a_done_one_cycle: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (state_q == MTC_DONE) |=> (state_q == MTC_IDLE)
            && (sel_q == `MTC_SEL_NONE))
        else $error("done state not left with idle code");

    a_done_irq: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (state_q == MTC_DONE) |=> sts_q[`MTC_IRQ_DONE])
        else $error("done event not flagged");

    a_other_code_nop: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        trig_rise && !is_clear && !in_fn
        |=> !busy_q && !o_wr_abort && $stable(o_abort_code))
        else $error("unsupported code acted");

    a_abort_pulse: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        o_wr_abort |=> !o_wr_abort)
        else $error("abort longer than one cycle");

    a_abort_cause: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !reject |=> !o_wr_abort)
        else $error("abort without refused start");

    a_reject_flags: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        reject |=> sts_q[`MTC_IRQ_ABORT] && refused_q)
        else $error("refusal not recorded");

    a_tool_refuse: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        trig_rise && is_clear && i_cond.tool_clear_busy
        |=> o_wr_abort && (o_abort_code == `MTC_ABORT_BUSY))
        else $error("tool clear in progress not refused");

    a_code_holds: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !go && !reject |=> $stable(o_abort_code))
        else $error("abort code changed without a start");

    a_code_clears: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        go |=> (o_abort_code == `MTC_ABORT_NONE) && !refused_q)
        else $error("accepted start kept old abort");

    a_prot_only_alt: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !i_alt_clear_req |=> !o_prot_err)
        else $error("protection error without other path");

    a_sel_kept_run: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        busy_q && !wr_sel |=> $stable(sel_q))
        else $error("selection changed during clear");

    a_no_start_held: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !trig_rise |=> !$rose(busy_q))
        else $error("clear started without start edge");

    a_irq_level: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        o_irq == (|(sts_q & msk_q)))
        else $error("interrupt line disagrees with status");

    a_mask_kept: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !wr_msk |=> $stable(msk_q))
        else $error("mask changed without a write");

    a_rdata_idle: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !i_rd |=> (o_rdata == 32'h00000000))
        else $error("read data outside read cycle");

    a_status_read: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_rd && mtc_hit(i_addr, `MTC_OFF_STATUS)
        |=> (o_rdata[`MTC_ST_BUSY] == $past(busy_q))
            && (o_rdata[`MTC_ST_REFUSED] == $past(refused_q)))
        else $error("status read wrong");

    a_sel_read: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_rd && mtc_hit(i_addr, `MTC_OFF_SELECT)
        |=> (o_rdata == {16'h0000, $past(sel_q)}))
        else $error("selection read wrong");

    a_abort_read: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_rd && mtc_hit(i_addr, `MTC_OFF_ABORT)
        |=> (o_rdata == $past(o_abort_code)))
        else $error("abort code read wrong");

endmodule : mtc_special_func

// File: rtl/mtc_defs.svh
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH

// Register offsets
`define MTC_OFF_FLAGS 8'h00
`define MTC_OFF_SELECT 8'h04
`define MTC_OFF_STATUS 8'h08
`define MTC_OFF_ABORT 8'h0C
`define MTC_OFF_IRQ_STS 8'h10
`define MTC_OFF_IRQ_MSK 8'h14

// Field positions
`define MTC_TRIG_BIT 9
`define MTC_ST_BUSY 0
`define MTC_ST_REFUSED 1
`define MTC_IRQ_DONE 0
`define MTC_IRQ_ABORT 1
`define MTC_IRQ_W 2

// Codes and reset values
`define MTC_SEL_NONE 16'h0000
`define MTC_SEL_CLEAR 16'h0031
`define MTC_ABS_SINGLE 16'h0003
`define MTC_ABORT_BUSY 32'h08000022
`define MTC_ABORT_NONE 32'h00000000
`define MTC_FLAGS_RST 32'h00000000
`define MTC_IRQ_RST 2'h0

// Timing
`define MTC_CLK_MHZ 40
`define MTC_CLEAR_NS 1000
`define MTC_CLEAR_CYC ((`MTC_CLEAR_NS * `MTC_CLK_MHZ + 999) / 1000)
`define MTC_CNT_W 8

`endif

// File: rtl/mtc_pkg.sv
package mtc_pkg;

    typedef struct packed {
        logic servo_on;
        logic tool_clear_busy;
        logic incr_encoder;
        logic probe_active;
        logic [15:0] abs_mode;
    } mtc_cond_t;

    typedef enum logic [1:0] {
        MTC_IDLE = 2'h0,
        MTC_RUN = 2'h1,
        MTC_DONE = 2'h3
    } mtc_state_t;

endpackage : mtc_pkg

// File: tb/mtc_master.sv
`timescale 1ns/1ps
`include "mtc_defs.svh"
module mtc_master (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask : rd
    // Select, trigger low, then trigger high; no state or mode requests
    task automatic start(input logic [15:0] sel);
        wr(`MTC_OFF_SELECT, {16'h0000, sel});
        wr(`MTC_OFF_FLAGS, 32'h0);
        wr(`MTC_OFF_FLAGS, 32'h1 << `MTC_TRIG_BIT);
    endtask : start
endmodule : mtc_master

// File: tb/tb_mtc_special_func.sv
`timescale 1ns/1ps
`include "mtc_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_mtc_special_func;
    import mtc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    mtc_cond_t cond = '0;
    logic alt = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv, code;
    logic wr, rd, abort, active, prot, irq;
    int err_count = 0;
    int num_checks = 0;
    logic [19:0] tbl [5] = '{20'h80000, 20'h40000, 20'h20000, 20'h10000,
        20'h00003};
    always #12.5 i_clk = ~i_clk;
    mtc_master i_mtc_master (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    mtc_special_func i_mtc_special_func (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_cond(cond),
        .i_alt_clear_req(alt), .o_rdata(rdata), .o_wr_abort(abort),
        .o_abort_code(code), .o_clear_active(active), .o_prot_err(prot),
        .o_irq(irq));
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        i_mtc_master.rd(a, rv);
        `CHK(rv, e)
    endtask : chk_rd
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask : step
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        chk_rd(`MTC_OFF_SELECT, 32'h0);
        chk_rd(8'h20, 32'h0);
        // Clear with servo off, probe idle, absolute encoder
        i_mtc_master.start(16'h0031);
        step();
        `CHK(active, 1'b1)
        i_mtc_master.wr(`MTC_OFF_FLAGS, 32'h0);
        #1;
        `CHK(active, 1'b1)
        i_mtc_master.wr(`MTC_OFF_FLAGS, 32'h200);
        #1;
        `CHK(abort, 1'b1)
        `CHK(prot, 1'b0)
        for (int k = 0; k < 100 && active !== 1'b0; k++) step();
        `CHK(active, 1'b0)
        if (active !== 1'b0) tally_and_finish();
        step();
        chk_rd(`MTC_OFF_SELECT, 32'h0);
        `CHK(irq, 1'b0)
        chk_rd(`MTC_OFF_IRQ_STS, 32'h3);
        i_mtc_master.wr(`MTC_OFF_IRQ_MSK, 32'h3);
        step();
        `CHK(irq, 1'b1)
        i_mtc_master.wr(`MTC_OFF_IRQ_STS, 32'h3);
        step();
        `CHK(irq, 1'b0)
        // Each refusing i_cond condition in turn
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clk);
            cond <= mtc_cond_t'(tbl[i]);
            i_mtc_master.start(16'h0031);
            #1;
            `CHK(abort, 1'b1)
            `CHK(code, 32'h08000022)
            `CHK(active, 1'b0)
            chk_rd(`MTC_OFF_SELECT, 32'h31);
            chk_rd(`MTC_OFF_STATUS, 32'h2);
            chk_rd(`MTC_OFF_ABORT, 32'h08000022);
        end
        @(posedge i_clk);
        cond <= '0;
        i_mtc_master.wr(`MTC_OFF_FLAGS, 32'h200);
        step();
        `CHK(active, 1'b0)
        i_mtc_master.start(16'h0000);
        step();
        `CHK(active, 1'b0)
        `CHK(code, 32'h08000022)
        i_mtc_master.start(16'h0007);
        #1;
        `CHK(abort, 1'b0)
        step();
        `CHK(active, 1'b0)
        i_mtc_master.start(16'h0031);
        #1;
        `CHK(code, 32'h0)
        chk_rd(`MTC_OFF_STATUS, 32'h1);
        @(posedge i_clk);
        alt <= 1'b1;
        @(posedge i_clk);
        alt <= 1'b0;
        #1;
        `CHK(prot, 1'b1)
        tally_and_finish();
    end
endmodule : tb_mtc_special_func
